// file: logic/hpr_pkg.sv
// constants, register map and sequencer states of the home return block
// assumes a 100 MHz system clock and an avalon-mm slave bus of 32 bits
package hpr_pkg;
   localparam int          HPR_CLK_MHZ      = 100;
   localparam int          HPR_AW           = 6;
   localparam int          HPR_DW           = 32;
   localparam int          HPR_SW           = 16;
   // register byte offsets
   localparam logic [5:0]  HPR_OFS_CTRL     = 6'h00;
   localparam logic [5:0]  HPR_OFS_CFG      = 6'h04;
   localparam logic [5:0]  HPR_OFS_HSPD     = 6'h08;
   localparam logic [5:0]  HPR_OFS_CREEP    = 6'h0C;
   localparam logic [5:0]  HPR_OFS_SHIFT    = 6'h10;
   localparam logic [5:0]  HPR_OFS_RAMP     = 6'h14;
   localparam logic [5:0]  HPR_OFS_HPOS     = 6'h18;
   localparam logic [5:0]  HPR_OFS_POSTDOG  = 6'h1C;
   localparam logic [5:0]  HPR_OFS_STATUS   = 6'h20;
   localparam logic [5:0]  HPR_OFS_CURPOS   = 6'h24;
   localparam logic [5:0]  HPR_OFS_REVPOS   = 6'h28;
   // field positions
   localparam int          HPR_CTRL_START   = 0;
   localparam int          HPR_CFG_METH_LSB = 0;
   localparam int          HPR_CFG_DIR      = 4;
   localparam int          HPR_CFG_POL      = 8;
   localparam int          HPR_ST_DONE      = 0;
   localparam int          HPR_ST_BUSY      = 1;
   localparam int          HPR_ST_MODE      = 2;
   localparam int          HPR_ST_STATE_LSB = 4;
   // method digit codes
   localparam logic [3:0]  HPR_METH_DOG     = 4'h0;
   localparam logic [3:0]  HPR_METH_COUNT   = 4'h1;
   // reset values
   localparam logic [31:0] HPR_RST_CFG      = 32'h0000_0000;
   localparam logic [31:0] HPR_RST_HSPD     = 32'h0000_0064;
   localparam logic [31:0] HPR_RST_CREEP    = 32'h0000_000A;
   localparam logic [31:0] HPR_RST_SHIFT    = 32'h0000_0000;
   localparam logic [31:0] HPR_RST_RAMP     = 32'h0000_0000;
   localparam logic [31:0] HPR_RST_HPOS     = 32'h0000_0000;
   localparam logic [31:0] HPR_RST_POSTDOG  = 32'h0000_0000;
   // encoder increments per motor revolution
   localparam logic [31:0] HPR_PULSES_REV   = 32'h0000_1000;

   typedef enum logic [2:0] {
      HPR_S_IDLE  = 3'b000,
      HPR_S_FAST  = 3'b001,
      HPR_S_CREEP = 3'b011,
      HPR_S_POST  = 3'b010,
      HPR_S_WAITZ = 3'b110,
      HPR_S_SHIFT = 3'b111,
      HPR_S_DONE  = 3'b101
   } hpr_state_t;
endpackage

// file: logic/hpr_home_return.sv
// dog and count type home return sequencer with avalon-mm registers
// assumes encoder increments and dog come from pins, one clock domain
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps

// Function
// - start is taken only while auto_manual_select is high
// - method digit zero selects dog referenced home return
// - method digit one selects count after dog home return
// - direction bit zero moves up in address, one moves down
// - polarity bit zero detects dog off, one detects dog on
// - before dog detection run at home return speed
// - after dog detection slow to creep speed
// - dog method homes on first marker after dog rear end plus shift
// - speed ramps by one step per ramp time constant period
// - on completion load current position from home position data
// - count method travels post dog distance then homes on next marker
// - within one revolution position is readable as status
// - revolution marker is made internally and never output
module hpr_home_return
   import hpr_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              sys_rst_i,
   input  wire logic [HPR_AW-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [HPR_DW-1:0] avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [HPR_DW-1:0] avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              auto_manual_select_i,
   input  wire logic              dog_i,
   input  wire logic              enc_pulse_i,
   output logic      [HPR_SW-1:0] motor_speed_o,
   output logic                   motor_dir_o,
   output logic                   home_busy_o,
   output logic                   home_done_o
);

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // pin synchronisers
   logic am_s1_q, am_s2_q, dog_s1_q, dog_s2_q;
   logic enc_s1_q, enc_s2_q, enc_s3_q;
   logic am_s1_d, am_s2_d, dog_s1_d, dog_s2_d;
   logic enc_s1_d, enc_s2_d, enc_s3_d;

   always_comb begin
      am_s1_d  = auto_manual_select_i;
      am_s2_d  = am_s1_q;
      dog_s1_d = dog_i;
      dog_s2_d = dog_s1_q;
      enc_s1_d = enc_pulse_i;
      enc_s2_d = enc_s1_q;
      enc_s3_d = enc_s2_q;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         am_s1_q  <= 1'b0;
         am_s2_q  <= 1'b0;
         dog_s1_q <= 1'b0;
         dog_s2_q <= 1'b0;
         enc_s1_q <= 1'b0;
         enc_s2_q <= 1'b0;
         enc_s3_q <= 1'b0;
      end else begin
         am_s1_q  <= am_s1_d;
         am_s2_q  <= am_s2_d;
         dog_s1_q <= dog_s1_d;
         dog_s2_q <= dog_s2_d;
         enc_s1_q <= enc_s1_d;
         enc_s2_q <= enc_s2_d;
         enc_s3_q <= enc_s3_d;
      end
   end

   // bus slave and parameter registers
   logic        ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] cfg_q, cfg_d, hspd_q, hspd_d, creep_q, creep_d;
   logic [31:0] shift_q, shift_d, ramp_q, ramp_d, hpos_q, hpos_d;
   logic [31:0] post_q, post_d;
   logic        wr_go, start;
   hpr_state_t  st_q, st_d;
   logic        done_q, done_d, dir_q, dir_d;
   logic [31:0] pos_q, pos_d, rev_q, rev_d, dist_q, dist_d;
   logic [31:0] rcnt_q, rcnt_d;
   logic [HPR_SW-1:0] spd_q, spd_d;
   logic [3:0]  meth;

   assign meth  = cfg_q[HPR_CFG_METH_LSB +: 4];
   // one wait state: request seen, answered on the following edge
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
   assign wr_go = avs_write_i & ack_q;
   // unsupported method digits refuse the start
   assign start = wr_go && avs_address_i == HPR_OFS_CTRL
                  && avs_byteenable_i[0]
                  && avs_writedata_i[HPR_CTRL_START] && am_s2_q
                  && st_q == HPR_S_IDLE && meth <= HPR_METH_COUNT;

   always_comb begin
      ack_d   = (avs_read_i | avs_write_i) & ~ack_q;
      rdata_d = rdata_q;
      cfg_d   = cfg_q;
      hspd_d  = hspd_q;
      creep_d = creep_q;
      shift_d = shift_q;
      ramp_d  = ramp_q;
      hpos_d  = hpos_q;
      post_d  = post_q;
      if (avs_read_i & ~ack_q) begin
         unique case (avs_address_i)
            HPR_OFS_CFG:     rdata_d = cfg_q;
            HPR_OFS_HSPD:    rdata_d = hspd_q;
            HPR_OFS_CREEP:   rdata_d = creep_q;
            HPR_OFS_SHIFT:   rdata_d = shift_q;
            HPR_OFS_RAMP:    rdata_d = ramp_q;
            HPR_OFS_HPOS:    rdata_d = hpos_q;
            HPR_OFS_POSTDOG: rdata_d = post_q;
            HPR_OFS_STATUS: begin
               rdata_d = 32'h0000_0000;
               rdata_d[HPR_ST_DONE] = done_q;
               rdata_d[HPR_ST_BUSY] = st_q != HPR_S_IDLE;
               rdata_d[HPR_ST_MODE] = am_s2_q;
               rdata_d[HPR_ST_STATE_LSB +: 3] = st_q;
            end
            HPR_OFS_CURPOS:  rdata_d = pos_q;
            HPR_OFS_REVPOS:  rdata_d = rev_q;
            default:         rdata_d = 32'h0000_0000;
         endcase
      end
      if (wr_go) begin
         unique case (avs_address_i)
            HPR_OFS_CFG:   cfg_d   = be_merge(cfg_q, avs_writedata_i,
                                              avs_byteenable_i);
            HPR_OFS_HSPD:  hspd_d  = be_merge(hspd_q, avs_writedata_i,
                                              avs_byteenable_i);
            HPR_OFS_CREEP: creep_d = be_merge(creep_q, avs_writedata_i,
                                              avs_byteenable_i);
            HPR_OFS_SHIFT: shift_d = be_merge(shift_q, avs_writedata_i,
                                              avs_byteenable_i);
            HPR_OFS_RAMP:  ramp_d  = be_merge(ramp_q, avs_writedata_i,
                                              avs_byteenable_i);
            HPR_OFS_HPOS:  hpos_d  = be_merge(hpos_q, avs_writedata_i,
                                              avs_byteenable_i);
            HPR_OFS_POSTDOG: post_d = be_merge(post_q, avs_writedata_i,
                                               avs_byteenable_i);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         cfg_q   <= HPR_RST_CFG;
         hspd_q  <= HPR_RST_HSPD;
         creep_q <= HPR_RST_CREEP;
         shift_q <= HPR_RST_SHIFT;
         ramp_q  <= HPR_RST_RAMP;
         hpos_q  <= HPR_RST_HPOS;
         post_q  <= HPR_RST_POSTDOG;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         cfg_q   <= cfg_d;
         hspd_q  <= hspd_d;
         creep_q <= creep_d;
         shift_q <= shift_d;
         ramp_q  <= ramp_d;
         hpos_q  <= hpos_d;
         post_q  <= post_d;
      end
   end
   assign avs_readdata_o = rdata_q;

   // sequencer, position tracking and speed ramp
   logic              enc_edge, dog_det, marker;
   logic [HPR_SW-1:0] target;

   assign enc_edge = enc_s2_q & ~enc_s3_q;
   assign dog_det  = cfg_q[HPR_CFG_POL] ? dog_s2_q : ~dog_s2_q;
   // marker kept internal; it is the wrap of the revolution count
   assign marker   = enc_edge && (dir_q ? rev_q == 32'h0000_0000
                               : rev_q == HPR_PULSES_REV - 1);

   always_comb begin
      st_d   = st_q;
      done_d = done_q;
      dir_d  = dir_q;
      pos_d  = pos_q;
      rev_d  = rev_q;
      dist_d = dist_q;
      rcnt_d = rcnt_q;
      spd_d  = spd_q;
      target = '0;
      if (enc_edge) begin
         pos_d = dir_q ? pos_q - 32'd1 : pos_q + 32'd1;
         if (marker) begin
            rev_d = dir_q ? HPR_PULSES_REV - 1 : 32'h0000_0000;
         end else begin
            rev_d = dir_q ? rev_q - 32'd1 : rev_q + 32'd1;
         end
         if (dist_q != 32'h0000_0000) begin
            dist_d = dist_q - 32'd1;
         end
      end
      unique case (st_q)
         HPR_S_IDLE: begin
            if (start) begin
               st_d   = HPR_S_FAST;
               done_d = 1'b0;
               dir_d  = cfg_q[HPR_CFG_DIR];
            end
         end
         HPR_S_FAST: begin
            target = hspd_q[HPR_SW-1:0];
            if (dog_det) begin
               if (meth == HPR_METH_COUNT) begin
                  st_d   = HPR_S_POST;
                  dist_d = post_q;
               end else begin
                  st_d = HPR_S_CREEP;
               end
            end
         end
         HPR_S_CREEP: begin
            target = creep_q[HPR_SW-1:0];
            if (!dog_det) begin
               st_d = HPR_S_WAITZ;
            end
         end
         HPR_S_POST: begin
            target = creep_q[HPR_SW-1:0];
            if (dist_q == 32'h0000_0000) begin
               st_d = HPR_S_WAITZ;
            end
         end
         HPR_S_WAITZ: begin
            target = creep_q[HPR_SW-1:0];
            if (marker) begin
               st_d   = HPR_S_SHIFT;
               dist_d = shift_q;
            end
         end
         HPR_S_SHIFT: begin
            target = creep_q[HPR_SW-1:0];
            if (dist_q == 32'h0000_0000) begin
               st_d = HPR_S_DONE;
            end
         end
         HPR_S_DONE: begin
            if (spd_q == '0) begin
               pos_d  = hpos_q;
               done_d = 1'b1;
               st_d   = HPR_S_IDLE;
            end
         end
         default: st_d = HPR_S_IDLE;
      endcase
      // one speed step per ramp period, zero period steps every cycle
      if (spd_q != target) begin
         if (rcnt_q >= ramp_q) begin
            rcnt_d = 32'h0000_0000;
            spd_d  = (spd_q < target) ? spd_q + 1'b1 : spd_q - 1'b1;
         end else begin
            rcnt_d = rcnt_q + 32'd1;
         end
      end else begin
         rcnt_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         st_q   <= HPR_S_IDLE;
         done_q <= 1'b0;
         dir_q  <= 1'b0;
         pos_q  <= 32'h0000_0000;
         rev_q  <= 32'h0000_0000;
         dist_q <= 32'h0000_0000;
         rcnt_q <= 32'h0000_0000;
         spd_q  <= '0;
      end else begin
         st_q   <= st_d;
         done_q <= done_d;
         dir_q  <= dir_d;
         pos_q  <= pos_d;
         rev_q  <= rev_d;
         dist_q <= dist_d;
         rcnt_q <= rcnt_d;
         spd_q  <= spd_d;
      end
   end

   assign motor_speed_o = spd_q;
   assign motor_dir_o   = dir_q;
   assign home_busy_o   = st_q != HPR_S_IDLE;
   assign home_done_o   = done_q;

   a_start_needs_mode: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_FAST && $past(st_q) == HPR_S_IDLE) |-> $past(am_s2_q))
      else $error("home return started outside manual mode");
   a_dog_method: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_FAST && dog_det && meth == HPR_METH_DOG)
      |=> st_q == HPR_S_CREEP)
      else $error("dog method did not enter creep on dog");
   a_count_method: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_FAST && dog_det && meth == HPR_METH_COUNT)
      |=> st_q == HPR_S_POST && dist_q == $past(post_q))
      else $error("count method did not load post dog distance");
   a_dir_latched: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      start |=> motor_dir_o == $past(cfg_q[HPR_CFG_DIR]))
      else $error("motion direction differs from configuration");
   a_dog_polarity: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_FAST && dog_s2_q != cfg_q[HPR_CFG_POL])
      |=> st_q == HPR_S_FAST)
      else $error("dog detected at wrong polarity");
   a_fast_limit: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_FAST && spd_q == hspd_q[HPR_SW-1:0])
      |=> spd_q == $past(spd_q) || st_q != HPR_S_FAST)
      else $error("speed left home return speed before dog");
   a_creep_slows: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_CREEP && spd_q > creep_q[HPR_SW-1:0])
      |=> spd_q <= $past(spd_q))
      else $error("speed rose above creep after dog");
   a_ramp_step: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      $changed(spd_q) |-> (spd_q == $past(spd_q) + 1'b1
                           || spd_q == $past(spd_q) - 1'b1))
      else $error("speed moved by more than one step");
   a_marker_shift: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_WAITZ && marker)
      |=> st_q == HPR_S_SHIFT && dist_q == $past(shift_q))
      else $error("marker did not start shift travel");
   a_home_load: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_q == HPR_S_DONE && spd_q == '0)
      |=> pos_q == $past(hpos_q) && home_done_o && !home_busy_o)
      else $error("home position not loaded on completion");
   a_done_clear: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      start |=> !home_done_o && home_busy_o)
      else $error("done flag not cleared at start");
   a_marker_wrap: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      marker |=> rev_q == ($past(dir_q) ? HPR_PULSES_REV - 1
                                        : 32'h0000_0000))
      else $error("revolution count not wrapped at marker");

endmodule // hpr_home_return

// file: testbench/hpr_motor_model.sv
// encoder and proximity dog model facing the home return block
// assumes one clock; position counts one per encoder pin rise
`timescale 1ns/10ps
module hpr_motor_model
   import hpr_pkg::*;
(
   input  wire logic               clk_sys_i,
   input  wire logic               sys_rst_i,
   input  wire logic [HPR_SW-1:0]  motor_speed_i,
   input  wire logic               motor_dir_i,
   input  wire logic               dog_pol_i,
   input  wire logic signed [31:0] dog_lo_i,
   input  wire logic signed [31:0] dog_hi_i,
   output logic                    dog_o,
   output logic                    enc_pulse_o,
   output logic signed [31:0]      pos_o
);
   int   phase_q;
   logic in_dog;

   assign in_dog = (pos_o >= dog_lo_i) && (pos_o < dog_hi_i);
   // switch is always driven, so no released level to model
   assign dog_o  = dog_pol_i ? in_dog : !in_dog;

   // slow pulses at low speed, so creep really is slower than fast run
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         phase_q     <= 0;
         enc_pulse_o <= 1'b0;
         pos_o       <= '0;
      end else if (motor_speed_i == '0) begin
         phase_q     <= 0;
         enc_pulse_o <= 1'b0;
      end else if (phase_q == 0) begin
         enc_pulse_o <= 1'b1;
         pos_o       <= motor_dir_i ? pos_o - 1 : pos_o + 1;
         phase_q     <= (motor_speed_i > 16'h0008) ? 1 : 5;
      end else begin
         enc_pulse_o <= 1'b0;
         phase_q     <= phase_q - 1;
      end
   end
endmodule // hpr_motor_model

// file: testbench/hpr_home_return_tb.sv
// self-checking bench for the home return block and its motor model
// assumes package constants as delivered and a 100 MHz clock
`timescale 1ns/10ps
module hpr_home_return_tb
   import hpr_pkg::*;
;
   localparam int REV = int'(HPR_PULSES_REV);
   logic               clk_sys_i, sys_rst_i, avs_read_i, avs_write_i;
   logic [HPR_AW-1:0]  avs_address_i;
   logic [HPR_DW-1:0]  avs_writedata_i, avs_readdata_o;
   logic [3:0]         avs_byteenable_i;
   logic               avs_waitrequest_o, auto_manual_select_i, dog_i;
   logic               enc_pulse_i, motor_dir_o, home_busy_o, home_done_o;
   logic [HPR_SW-1:0]  motor_speed_o;
   logic               dog_pol;
   logic signed [31:0] dog_lo, dog_hi, pos;
   logic [31:0]        exp_q[$];
   int                 fail_count, tests_run, n, m;
   logic [5:0]  ofs [9] = '{HPR_OFS_CTRL, HPR_OFS_CFG, HPR_OFS_HSPD,
      HPR_OFS_CREEP, HPR_OFS_SHIFT, HPR_OFS_RAMP, HPR_OFS_HPOS,
      HPR_OFS_POSTDOG, 6'h2C};
   logic [31:0] rst [9] = '{32'h0000_0000, HPR_RST_CFG, HPR_RST_HSPD,
      HPR_RST_CREEP, HPR_RST_SHIFT, HPR_RST_RAMP, HPR_RST_HPOS,
      HPR_RST_POSTDOG, 32'h0000_0000};

   hpr_motor_model u_motor (
      .clk_sys_i     (clk_sys_i),
      .sys_rst_i     (sys_rst_i),
      .motor_speed_i (motor_speed_o),
      .motor_dir_i   (motor_dir_o),
      .dog_pol_i     (dog_pol),
      .dog_lo_i      (dog_lo),
      .dog_hi_i      (dog_hi),
      .dog_o         (dog_i),
      .enc_pulse_o   (enc_pulse_i),
      .pos_o         (pos)
   );

   hpr_home_return uut (
      .clk_sys_i            (clk_sys_i),
      .sys_rst_i            (sys_rst_i),
      .avs_address_i        (avs_address_i),
      .avs_read_i           (avs_read_i),
      .avs_write_i          (avs_write_i),
      .avs_writedata_i      (avs_writedata_i),
      .avs_byteenable_i     (avs_byteenable_i),
      .avs_readdata_o       (avs_readdata_o),
      .avs_waitrequest_o    (avs_waitrequest_o),
      .auto_manual_select_i (auto_manual_select_i),
      .dog_i                (dog_i),
      .enc_pulse_i          (enc_pulse_i),
      .motor_speed_o        (motor_speed_o),
      .motor_dir_o          (motor_dir_o),
      .home_busy_o          (home_busy_o),
      .home_done_o          (home_done_o)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic rd, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_read_i      <= rd;
      avs_write_i     <= !rd;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b1, a, 32'h0000_0000);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys_i);
   endtask

   task automatic wait_speed(input logic [15:0] v, input int lim);
      for (int i = 0; i < lim && motor_speed_o !== v; i++)
         @(negedge clk_sys_i);
   endtask

   // one full sequence; mk is the revolution wrap that must be homed on
   task automatic home_run(input logic [31:0] cfg, input int mk,
                           input int lo, input int hi);
      logic [31:0]        shift, hpos;
      logic [15:0]        hs;
      logic signed [31:0] home, d;
      logic               dir;
      shift = $urandom_range(15);
      hpos  = $urandom;
      hs    = 16'($urandom_range(60, 30));
      dir   = cfg[HPR_CFG_DIR];
      home  = dir ? mk - 1 - shift : mk + shift;
      @(posedge clk_sys_i);
      dog_lo  <= lo;
      dog_hi  <= hi;
      dog_pol <= cfg[HPR_CFG_POL];
      wr(HPR_OFS_CFG, cfg);
      wr(HPR_OFS_HSPD, {16'h0000, hs});
      wr(HPR_OFS_CREEP, 32'h0000_0005);
      wr(HPR_OFS_RAMP, 32'h0000_0003);
      wr(HPR_OFS_SHIFT, shift);
      wr(HPR_OFS_HPOS, hpos);
      wr(HPR_OFS_POSTDOG, 32'h0000_0096);
      wr(HPR_OFS_CTRL, 32'h0000_0001);
      cyc(2);
      check(home_done_o, 1'b0);
      check(home_busy_o, 1'b1);
      wait_speed(16'h0001, 50);
      for (n = 0; n < 50 && motor_speed_o !== 16'h0002; n++)
         @(negedge clk_sys_i);
      check(n, 32'h0000_0004);
      wait_speed(hs, 1000);
      check(motor_speed_o, hs);
      check(motor_dir_o, dir);
      wait_speed(16'h0005, 12000);
      check(motor_speed_o, 16'h0005);
      check(pos >= lo && pos < hi, 1'b1);
      for (n = 0; n < 30000 && motor_speed_o >= 16'h0005; n++)
         @(negedge clk_sys_i);
      // the last increment may still be in the pin synchroniser
      d = dir ? home - pos : pos - home;
      check(d >= 0 && d <= 1, 1'b1);
      for (n = 0; n < 200 && home_done_o !== 1'b1; n++)
         @(negedge clk_sys_i);
      check(home_busy_o, 1'b0);
      check(motor_speed_o, 16'h0000);
      rd(HPR_OFS_CURPOS, hpos);
      rd(HPR_OFS_STATUS, 32'h0000_0005);
      rd(HPR_OFS_REVPOS, pos & (HPR_PULSES_REV - 1));
   endtask

   // read results are matched against notes in arrival order
   always @(posedge clk_sys_i)
      if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
         check(avs_readdata_o, exp_q.pop_front());

   task automatic final_report();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      repeat (90000) @(posedge clk_sys_i);
      fail_count++;
      final_report();
   end

   initial begin
      sys_rst_i = 1'b1;
      avs_address_i = '0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = '0;
      avs_byteenable_i = 4'hF;
      auto_manual_select_i = 1'b0;
      dog_pol = 1'b1;
      dog_lo = '0;
      dog_hi = '0;
      fail_count = 0;
      tests_run = 0;
      void'($urandom(32'h6cb5));
      repeat (12) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      foreach (ofs[i]) rd(ofs[i], rst[i]);
      rd(HPR_OFS_REVPOS, 32'h0000_0000);
      wr(HPR_OFS_STATUS, 32'hFFFF_FFFF);
      rd(HPR_OFS_STATUS, 32'h0000_0000);
      wr(HPR_OFS_CFG, 32'h0000_0100);
      wr(HPR_OFS_CTRL, 32'h0000_0001);
      cyc(4);
      check(home_busy_o, 1'b0);
      @(posedge clk_sys_i);
      auto_manual_select_i <= 1'b1;
      wr(HPR_OFS_CFG, 32'h0000_0002);
      wr(HPR_OFS_CTRL, 32'h0000_0001);
      cyc(4);
      check(home_busy_o, 1'b0);
      rd(HPR_OFS_STATUS, 32'h0000_0004);
      // dog method, rising address, dog seen while input on
      m = ((pos + 600) / REV + 1) * REV;
      home_run(32'h0000_0100, m, m - 400, m - 20);
      // count method, falling address, dog seen while input off
      m = ((pos - 800) / REV) * REV;
      home_run(32'h0000_0011, m, m - 500, m + 400);
      final_report();
   end
endmodule // hpr_home_return_tb
